/* core/bsf_cfg.svh */
// Constants for the bit, shift, flag and control execution unit.
// Assumes an 8-bit status register and a one-clock core.
//
// Operation
// - Rotate left through carry, flags Z,C,N,V,S,H
// - Rotate right through carry, flags Z,C,N,V,S
// - I/O bit set, no flags, two cycles
// - I/O bit clear, no flags, two cycles
// - Register bit copied into transfer flag
// - Transfer flag copied into register bit
// - Overflow flag set and clear only
// - Half-carry flag set and clear only
// - Signed-test flag set and clear only
// - Debug break: one cycle, flags kept
// - Sleep: one cycle, flags kept
// - Watchdog restart: one cycle, pulse watchdog
// - Listed data counts mean internal RAM
// - Non-volatile path adds one or more cycles
// - Low 64-byte I/O access adds one cycle
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH
`define FLAG_C        3'd0
`define FLAG_Z        3'd1
`define FLAG_N        3'd2
`define FLAG_V        3'd3
`define FLAG_S        3'd4
`define FLAG_H        3'd5
`define FLAG_T        3'd6
`define FLAG_I        3'd7
`define STATUS_RESET  8'h00
`define IO_LOW_LIMIT  6'h3f
`define NONVOL_MIN_EXTRA 1'b1
`endif

/* core/bsf_pkg.sv */
// Types for the bit, shift, flag and control execution unit.
// Assumes inclusion of bsf_cfg.svh by the design files.
package bsf_pkg;
    typedef enum logic [4:0] {
        OP_NONE      = 5'h00,
        OP_SHL       = 5'h01,
        OP_SHR       = 5'h02,
        OP_ROT_L     = 5'h03,
        OP_ROT_R     = 5'h04,
        OP_SAR       = 5'h05,
        OP_SWAP      = 5'h06,
        OP_IO_SET    = 5'h07,
        OP_IO_CLR    = 5'h08,
        OP_BIT_TO_T  = 5'h09,
        OP_T_TO_BIT  = 5'h0a,
        OP_FLAG_SET  = 5'h0b,
        OP_FLAG_CLR  = 5'h0c,
        OP_BREAK     = 5'h0d,
        OP_SLEEP     = 5'h0e,
        OP_WD_RESTART = 5'h0f,
        OP_NOP       = 5'h10,
        OP_MEM       = 5'h11
    } op_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_IO_WR = 2'b01,
        ST_WAIT  = 2'b10
    } state_t;
endpackage

/* core/io_port_if.sv */
// Interface carrying I/O read-modify-write traffic inside the unit.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface io_port_if;
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output rd, output wr, output addr, output wdata, input rdata);
    modport slave  (input rd, input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* core/io_bit_rmw.sv */
// Read-modify-write of one I/O bit over two cycles.
// Assumes the I/O space answers a read in the same cycle.
`include "bsf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module io_bit_rmw
    import bsf_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Request
    input  wire logic       start,
    input  wire logic       set_not_clr,
    input  wire logic [5:0] addr,
    input  wire logic [2:0] bit_sel,
    // I/O side
    io_port_if.master       io,
    // Status
    output logic            busy
);
    logic       phase_reg;
    logic       val_reg;
    logic [5:0] addr_reg;
    logic [2:0] bit_reg;
    logic [7:0] merged;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 1'b0;
            val_reg   <= 1'b0;
            addr_reg  <= 6'h00;
            bit_reg   <= 3'h0;
        end else begin
            phase_reg <= start && !phase_reg;
            if (start && !phase_reg) begin
                val_reg  <= set_not_clr;
                addr_reg <= addr;
                bit_reg  <= bit_sel;
            end
        end
    end

    always_comb begin
        merged          = io.rdata;
        merged[bit_reg] = val_reg;
    end

    assign io.rd    = start && !phase_reg;
    assign io.wr    = phase_reg;
    assign io.addr  = phase_reg ? addr_reg : addr;
    assign io.wdata = merged;
    assign busy     = phase_reg;
endmodule // io_bit_rmw
`default_nettype wire

/* core/bit_shift_flag_unit.sv */
// Execution unit for shifts, bit moves, flag changes and control ops.
// Assumes the decoder holds op and operands until done pulses.
`include "bsf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_unit
    import bsf_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Decoder side
    input  wire logic       op_valid,
    input  wire logic [4:0] op_code,
    input  wire logic [7:0] src_data,
    input  wire logic [2:0] bit_sel,
    input  wire logic [5:0] io_addr,
    input  wire logic       mem_nonvol,
    input  wire logic       mem_io_low,
    input  wire logic       mem_base_extra,
    // Register file side
    output logic            rd_we,
    output logic [7:0]      rd_data,
    output logic [7:0]      status_register,
    output logic            done,
    // I/O space
    output logic            io_rd,
    output logic            io_wr,
    output logic [5:0]      io_addr_out,
    output logic [7:0]      io_wdata,
    input  wire logic [7:0] io_rdata,
    // Non-volatile memory controller
    input  wire logic       nonvol_ready,
    // System control
    output logic            break_pulse,
    output logic            sleep_pulse,
    output logic            watchdog_restart
);
    op_t        op;
    state_t     state_reg;
    state_t     state_next;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] res;
    logic [7:0] rd_data_reg;
    logic       rd_we_reg;
    logic       res_we;
    logic       rmw_busy;
    logic       extra_reg;
    logic       io_pend_reg;
    logic       wait_done;
    logic       shift_op;

    io_port_if io_bus ();

    assign op = op_t'(op_code);

    // Shared flag update after a shift
    function automatic logic [7:0] shift_flags(input logic [7:0] s, input logic [7:0] r,
                                               input logic c, input logic h_upd,
                                               input logic h);
        logic [7:0] f;
        f = s;
        f[`FLAG_C] = c;
        f[`FLAG_Z] = (r == 8'h00);
        f[`FLAG_N] = r[7];
        f[`FLAG_V] = r[7] ^ c;
        f[`FLAG_S] = r[7] ^ (r[7] ^ c);
        if (h_upd) f[`FLAG_H] = h;
        return f;
    endfunction

    io_bit_rmw u_rmw (
        .sys_clk     (sys_clk),
        .arst_n      (arst_n),
        .start       (op_valid && state_reg == ST_IDLE
                      && (op == OP_IO_SET || op == OP_IO_CLR)),
        .set_not_clr (op == OP_IO_SET),
        .addr        (io_addr),
        .bit_sel     (bit_sel),
        .io          (io_bus.master),
        .busy        (rmw_busy)
    );
    assign io_rd           = io_bus.rd;
    assign io_wr           = io_bus.wr;
    assign io_addr_out     = io_bus.addr;
    assign io_wdata        = io_bus.wdata;
    assign io_bus.rdata    = io_rdata;

    // Result and flag computation
    always_comb begin
        res        = src_data;
        flags_next = flags_reg;
        res_we     = 1'b0;
        shift_op   = 1'b0;
        if (op_valid && state_reg == ST_IDLE) begin
            unique case (op)
                OP_SHL: begin
                    res = {src_data[6:0], 1'b0};
                    res_we = 1'b1;
                    flags_next = shift_flags(flags_reg, res, src_data[7], 1'b1, src_data[3]);
                end
                OP_SHR: begin
                    res = {1'b0, src_data[7:1]};
                    res_we = 1'b1;
                    flags_next = shift_flags(flags_reg, res, src_data[0], 1'b0, 1'b0);
                end
                OP_ROT_L: begin
                    res = {src_data[6:0], flags_reg[`FLAG_C]};
                    res_we = 1'b1;
                    flags_next = shift_flags(flags_reg, res, src_data[7], 1'b1, src_data[3]);
                end
                OP_ROT_R: begin
                    res = {flags_reg[`FLAG_C], src_data[7:1]};
                    res_we = 1'b1;
                    flags_next = shift_flags(flags_reg, res, src_data[0], 1'b0, 1'b0);
                end
                OP_SAR: begin
                    res = {src_data[7], src_data[7:1]};
                    res_we = 1'b1;
                    flags_next = shift_flags(flags_reg, res, src_data[0], 1'b0, 1'b0);
                end
                OP_SWAP: begin
                    res = {src_data[3:0], src_data[7:4]};
                    res_we = 1'b1;
                end
                OP_BIT_TO_T: flags_next[`FLAG_T] = src_data[bit_sel];
                OP_T_TO_BIT: begin
                    res[bit_sel] = flags_reg[`FLAG_T];
                    res_we = 1'b1;
                end
                OP_FLAG_SET: flags_next[bit_sel] = 1'b1;
                OP_FLAG_CLR: flags_next[bit_sel] = 1'b0;
                default: ;
            endcase
        end
    end

    // Multi-cycle sequencing
    assign wait_done = !extra_reg && !io_pend_reg && (!mem_nonvol || nonvol_ready);
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (op_valid && (op == OP_IO_SET || op == OP_IO_CLR))
                    state_next = ST_IO_WR;
                else if (op_valid && op == OP_MEM
                         && (mem_base_extra || mem_nonvol || mem_io_low))
                    state_next = ST_WAIT;
            end
            ST_IO_WR: state_next = ST_IDLE;
            ST_WAIT:  if (wait_done) state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) state_reg <= ST_IDLE;
        else         state_reg <= state_next;
    end

    // Extra-cycle counters for memory accesses
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_reg   <= 1'b0;
            io_pend_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && state_next == ST_WAIT) begin
            extra_reg   <= mem_base_extra && (mem_nonvol || mem_io_low);
            io_pend_reg <= mem_io_low && mem_nonvol;
        end else if (state_reg == ST_WAIT) begin
            if (extra_reg)         extra_reg   <= 1'b0;
            else if (io_pend_reg)  io_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) flags_reg <= `STATUS_RESET;
        else         flags_reg <= flags_next;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= 8'h00;
            rd_we_reg   <= 1'b0;
        end else begin
            rd_we_reg <= res_we;
            if (res_we) rd_data_reg <= res;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            break_pulse      <= 1'b0;
            sleep_pulse      <= 1'b0;
            watchdog_restart <= 1'b0;
        end else begin
            break_pulse      <= op_valid && state_reg == ST_IDLE && op == OP_BREAK;
            sleep_pulse      <= op_valid && state_reg == ST_IDLE && op == OP_SLEEP;
            watchdog_restart <= op_valid && state_reg == ST_IDLE && op == OP_WD_RESTART;
        end
    end

    // Completion; non-volatile path waits at least one cycle for ready
    always_comb begin
        done = 1'b0;
        unique case (state_reg)
            ST_IDLE:  done = op_valid && state_next == ST_IDLE;
            ST_IO_WR: done = rmw_busy;
            ST_WAIT:  done = wait_done;
            default:  done = 1'b0;
        endcase
    end

    assign rd_we           = rd_we_reg;
    assign rd_data         = rd_data_reg;
    assign status_register = flags_reg;
endmodule // bit_shift_flag_unit
`default_nettype wire

/* testbench/io_space_model.sv */
// Model of the 64-byte I/O register space.
// Assumes reads are answered in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module io_space_model (
    // Clock
    input  wire logic       sys_clk,
    // Unit side
    input  wire logic       io_rd,
    input  wire logic       io_wr,
    input  wire logic [5:0] io_addr_out,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata
);
    logic [7:0] mem [64];
    logic [7:0] last_reg = 8'h00;
    always @(posedge sys_clk) begin
        if (io_wr) mem[io_addr_out] <= io_wdata;
        if (io_rd || io_wr) last_reg <= io_rdata;
    end
    // Released bus shows the inverse of the last byte
    assign io_rdata = (io_rd || io_wr) ? mem[io_addr_out] : ~last_reg;
endmodule // io_space_model
`default_nettype wire

/* testbench/bit_shift_flag_unit_monitor.sv */
// Checks on the execution unit's ports.
// Assumes binding into the unit from the bench.
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_unit_monitor
    import bsf_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // Watched ports
    input wire logic       op_valid,
    input wire logic [4:0] op_code,
    input wire logic [7:0] src_data,
    input wire logic [2:0] bit_sel,
    input wire logic       mem_nonvol,
    input wire logic       nonvol_ready,
    input wire logic       done,
    input wire logic       rd_we,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] status_register,
    input wire logic       io_rd,
    input wire logic       io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       watchdog_restart
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_rmw_end;
        io_wr && done;
    endsequence
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    a_io_two_cycle: assert property (io_rd |=> s_rmw_end)
        else $error("io update length wrong");
    a_io_kept_flags: assert property (io_rd |=> $stable(status_register) [*2])
        else $error("io op changed flags");
    a_io_set_bit: assert property (
        io_wr && op_code == OP_IO_SET |-> io_wdata == (io_rdata | (8'h01 << bit_sel)))
        else $error("io set byte wrong");
    a_io_clear_bit: assert property (
        io_wr && op_code == OP_IO_CLR |-> io_wdata == (io_rdata & ~(8'h01 << bit_sel)))
        else $error("io clear byte wrong");
    a_single_done: assert property (
        op_valid && op_code inside {[OP_SHL:OP_SWAP], [OP_BIT_TO_T:OP_WD_RESTART]} |-> done)
        else $error("single cycle op late");
    a_rol_carry_in: assert property (op_valid && op_code == OP_ROT_L |=> rd_we &&
        {status_register[0], rd_data} == {$past(src_data), $past(status_register[0])})
        else $error("rotate left wrong");
    a_flag_set_one: assert property (op_valid && op_code == OP_FLAG_SET |=>
        status_register == ($past(status_register) | (8'h01 << $past(bit_sel))))
        else $error("flag set wrong");
    a_ctrl_kept_flags: assert property (
        op_valid && op_code inside {OP_T_TO_BIT, OP_SLEEP, OP_WD_RESTART}
        |=> $stable(status_register))
        else $error("flags changed");
    a_wdr_pulse: assert property (
        op_valid && op_code == OP_WD_RESTART |=> s_pulse(watchdog_restart))
        else $error("no restart pulse");
    a_nonvol_wait: assert property (
        op_valid && op_code == OP_MEM && mem_nonvol && !nonvol_ready |-> !done)
        else $error("done before non-volatile ready");
endmodule // bit_shift_flag_unit_monitor
`default_nettype wire

/* testbench/test_bit_shift_flag_unit.sv */
// Self-checking bench for the execution unit.
// Assumes core sources, I/O model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_bit_shift_flag_unit;
    import bsf_pkg::*;
    logic       sys_clk, arst_n, op_valid, mem_nonvol, mem_io_low, mem_base_extra, nonvol_ready;
    logic       rd_we, done, io_rd, io_wr, break_pulse, sleep_pulse, watchdog_restart;
    logic [4:0] op_code;
    logic [2:0] bit_sel;
    logic [5:0] io_addr, io_addr_out;
    logic [7:0] src_data, rd_data, status_register, io_wdata, io_rdata, st;
    int         n_fail, num_checks, cyc;
    bit_shift_flag_unit i_dut (.sys_clk, .arst_n, .op_valid, .op_code, .src_data, .bit_sel,
        .io_addr, .mem_nonvol, .mem_io_low, .mem_base_extra, .rd_we, .rd_data, .status_register,
        .done, .io_rd, .io_wr, .io_addr_out, .io_wdata, .io_rdata, .nonvol_ready, .break_pulse,
        .sleep_pulse, .watchdog_restart);
    io_space_model i_io (.sys_clk, .io_rd, .io_wr, .io_addr_out, .io_wdata, .io_rdata);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: cycles %h expected %h", $time, got, lo);
        end
    endtask
    task automatic run(input op_t op, input logic [7:0] s, input logic [2:0] b);
        @(negedge sys_clk);
        op_code = op;
        src_data = s;
        bit_sel = b;
        op_valid = 1'b1;
        cyc = 0;
        #1;
        while (done !== 1'b1 && cyc < 40) begin
            @(negedge sys_clk);
            #1;
            cyc++;
        end
        if (cyc >= 40) begin
            n_fail++;
            $display("unexpected at %0t: done %h expected %h", $time, 1'b0, 1'b1);
        end
        @(negedge sys_clk);
        op_valid = 1'b0;
    endtask
    task automatic t_flags();
        for (int i = 0; i < 16; i++) begin
            run(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 8'h00, 3'(i));
            st[i % 8] = (i < 8);
            chk8(status_register, st);
        end
    endtask
    task automatic t_shift();
        logic [7:0] vals [4] = '{8'h81, 8'h4c, 8'h01, 8'h80};
        logic [8:0] e;
        op_t        op;
        for (int i = 0; i < 24; i++) begin
            op = op_t'(5'(i % 6 + 1));
            run((i / 6) % 2 ? OP_FLAG_SET : OP_FLAG_CLR, 8'h00, 3'd0);
            st[0] = 1'((i / 6) % 2);
            case (op)
                OP_SHL: e = {vals[i / 6], 1'b0};
                OP_SHR: e = {vals[i / 6][0], 1'b0, vals[i / 6][7:1]};
                OP_ROT_L: e = {vals[i / 6], st[0]};
                OP_ROT_R: e = {vals[i / 6][0], st[0], vals[i / 6][7:1]};
                OP_SAR: e = {vals[i / 6][0], vals[i / 6][7], vals[i / 6][7:1]};
                default: e = {st[0], vals[i / 6][3:0], vals[i / 6][7:4]};
            endcase
            if (op == OP_SHL || op == OP_ROT_L) st[5] = vals[i / 6][3];
            if (op != OP_SWAP) st[4:0] = {e[8], e[7] ^ e[8], e[7], e[7:0] == 8'h00, e[8]};
            run(op, vals[i / 6], 3'd0);
            chk8(rd_data, e[7:0]);
            chk8(status_register, st);
        end
    endtask
    task automatic t_bits();
        run(OP_BIT_TO_T, 8'h20, 3'd5);
        st[6] = 1'b1;
        chk8(status_register, st);
        run(OP_T_TO_BIT, 8'h00, 3'd2);
        chk8(rd_data, 8'h04);
        chk8(status_register, st);
    endtask
    task automatic t_io(input op_t op, input logic [5:0] a, input logic [2:0] b,
                        input logic [7:0] v, input logic [7:0] e);
        i_io.mem[a] = v;
        io_addr = a;
        run(op, 8'h00, b);
        chk_cyc(cyc, 1, 1);
        chk8(i_io.mem[a], e);
        chk8(status_register, st);
    endtask
    task automatic t_ctrl();
        for (int i = 0; i < 3; i++) begin
            run(op_t'(5'(13 + i)), 8'h00, 3'd0);
            chk8({5'h00, break_pulse, sleep_pulse, watchdog_restart}, 8'h04 >> i);
            chk8(status_register, st);
            chk_cyc(cyc, 0, 0);
        end
    endtask
    task automatic t_mem(input logic [2:0] m, input int wait_n, input int lo, input int hi);
        {mem_nonvol, mem_io_low, mem_base_extra} = m;
        nonvol_ready = 1'b0;
        fork
            run(OP_MEM, 8'h00, 3'd0);
            begin
                repeat (wait_n) @(negedge sys_clk);
                nonvol_ready = 1'b1;
            end
        join
        chk_cyc(cyc, lo, hi);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #20us;
        n_fail++;
        conclude();
    end
    initial begin
        {arst_n, op_valid, op_code, src_data, bit_sel, io_addr} = '0;
        {mem_nonvol, mem_io_low, mem_base_extra, nonvol_ready, st} = '0;
        repeat (8) @(negedge sys_clk);
        arst_n = 1'b1;
        chk8(status_register, 8'h00);
        t_flags();
        t_shift();
        t_bits();
        t_io(OP_IO_SET, 6'h15, 3'd3, 8'ha0, 8'ha8);
        t_io(OP_IO_CLR, 6'h3f, 3'd7, 8'hff, 8'h7f);
        t_ctrl();
        t_mem(3'b100, 1, 1, 2);
        t_mem(3'b100, 4, 3, 4);
        t_mem(3'b000, 1, 0, 0);
        t_mem(3'b010, 1, 1, 1);
        t_mem(3'b011, 1, 2, 2);
        t_mem(3'b110, 1, 2, 2);
        t_mem(3'b111, 1, 3, 3);
        conclude();
    end
endmodule // test_bit_shift_flag_unit
bind bit_shift_flag_unit bit_shift_flag_unit_monitor i_mon (.sys_clk, .arst_n, .op_valid,
    .op_code, .src_data, .bit_sel, .mem_nonvol, .nonvol_ready, .done, .rd_we, .rd_data,
    .status_register, .io_rd, .io_wr, .io_wdata, .io_rdata, .watchdog_restart);
`default_nettype wire
